// ===== src/sac_ctrl.sv
/*
 * sac_ctrl: control of an 8-bit successive-approximation converter with
 * input selector, gain stage, conversion clock divider, start sources,
 * busy and completion flags and track-and-hold modes, on classic Wishbone.
 * Assumes a synchronous comparator input and a one-cycle timer 2 overflow.
 */
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
module sac_ctrl
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        t2_ovf_i,
    input  wire logic        cmp_i,
    input  wire logic        sleep_i,
    input  wire logic        int_en_i,
    output logic             conv_power_o,
    output logic             track_o,
    output logic             sel_en_o,
    output logic      [31:0] ain_sel_o,
    output logic      [5:0]  gain_sel_o,
    output logic      [7:0]  dac_o,
    output logic             busy_o,
    output logic             done_flag_o,
    output logic             irq_o
);
    typedef struct packed {
        logic                sel_en;
        logic [1:0]          port;
        logic [2:0]          pin;
        logic [2:0]          div;
        logic [2:0]          gain;
        logic                en;
        logic                tm;
        logic                flag;
        logic [1:0]          stm;
        sac_pkg::sac_state_t st;
        logic [2:0]          bitn;
        logic [1:0]          tcnt;
        logic [7:0]          sar;
        logic [7:0]          result;
        logic                ack;
        logic [31:0]         rdat;
        logic [31:0]         ain_oh;
        logic [5:0]          gain_oh;
    } sac_regs_t;

    sac_regs_t   r_reg;
    sac_regs_t   r_next;
    sac_div_if   dif ();

    logic        acc;
    logic        wr;
    logic [7:0]  idx;
    logic [7:0]  wbyte;
    logic        busy;
    logic        sw_go;
    logic        t2_go;
    logic        go;
    logic        go_tm;
    logic        tick;
    logic [7:0]  bit_mask;
    logic [7:0]  sar_kept;
    logic        conv_last;
    logic [31:0] ain_next;
    logic [4:0]  ain_idx_next;
    logic        sel_en_next;

    sac_clkdiv u_div
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .dif   (dif)
    );

    assign acc   = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    // a write lands at the edge where the master samples ack, not before
    assign wr    = wb_cyc_i & wb_stb_i & r_reg.ack & wb_we_i & wb_sel_i[0];
    assign idx   = wb_adr_i[9:2];
    assign wbyte = wb_dat_i[7:0];
    assign busy  = (r_reg.st != sac_pkg::SAC_IDLE);

    // start fields are taken from the write itself, so one write may
    // enable, choose the mode and start at once
    assign sw_go = wr & (idx == sac_pkg::IDX_CTRL) & wbyte[sac_pkg::CTRL_BUSY_BIT]
                 & wbyte[sac_pkg::CTRL_EN_BIT]
                 & (wbyte[sac_pkg::CTRL_STM_LSB +: 2] == sac_pkg::STM_SW);
    assign t2_go = t2_ovf_i & r_reg.en & (r_reg.stm == sac_pkg::STM_T2);
    assign go    = (sw_go | t2_go) & ~busy;
    assign go_tm = sw_go ? wbyte[sac_pkg::CTRL_TM_BIT] : r_reg.tm;

    assign dif.code = r_reg.div;
    assign dif.run  = r_reg.en & busy;
    assign tick     = dif.tick;

    assign bit_mask  = sac_pkg::SAR_ONE << r_reg.bitn;
    // comparator high means the input is at or above the trial level
    assign sar_kept  = cmp_i ? r_reg.sar : (r_reg.sar & ~bit_mask);
    assign conv_last = (r_reg.st == sac_pkg::SAC_CONV) & tick & (r_reg.bitn == 3'h0);

    always_comb
    begin
        sel_en_next  = r_reg.sel_en;
        ain_idx_next = {r_reg.port, r_reg.pin};
        if (wr && idx == sac_pkg::IDX_INSEL)
        begin
            sel_en_next  = wbyte[sac_pkg::INSEL_EN_BIT];
            ain_idx_next = wbyte[4:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_ain
            assign ain_next[gi] = sel_en_next & (ain_idx_next == 5'(gi));
        end
    endgenerate

    always_comb
    begin
        r_next        = r_reg;
        r_next.ack    = acc;
        r_next.rdat   = 32'h0000_0000;
        r_next.ain_oh = ain_next;

        if (acc && !wb_we_i)
        begin
            case (idx)
                sac_pkg::IDX_INSEL:
                    r_next.rdat = {24'h00_0000, 2'b00, r_reg.sel_en, r_reg.port, r_reg.pin};
                sac_pkg::IDX_CFG:
                    r_next.rdat = {24'h00_0000, r_reg.div, 2'b00, r_reg.gain};
                sac_pkg::IDX_CTRL:
                    r_next.rdat = {24'h00_0000, r_reg.en, r_reg.tm, r_reg.flag, busy,
                                   r_reg.stm, 2'b00};
                sac_pkg::IDX_RESULT:
                    r_next.rdat = {24'h00_0000, r_reg.result};
                default:
                    r_next.rdat = 32'h0000_0000;
            endcase
        end

        if (wr)
        begin
            case (idx)
                sac_pkg::IDX_INSEL:
                begin
                    r_next.sel_en = wbyte[sac_pkg::INSEL_EN_BIT];
                    r_next.port   = wbyte[sac_pkg::PORT_LSB +: 2];
                    r_next.pin    = wbyte[sac_pkg::PIN_LSB +: 3];
                end
                sac_pkg::IDX_CFG:
                begin
                    r_next.div     = wbyte[sac_pkg::CFG_DIV_LSB +: 3];
                    r_next.gain    = wbyte[sac_pkg::CFG_GAIN_LSB +: 3];
                    r_next.gain_oh = sac_pkg::sac_gain_onehot(
                                         wbyte[sac_pkg::CFG_GAIN_LSB +: 3]);
                end
                sac_pkg::IDX_CTRL:
                begin
                    r_next.en   = wbyte[sac_pkg::CTRL_EN_BIT];
                    r_next.tm   = wbyte[sac_pkg::CTRL_TM_BIT];
                    r_next.flag = wbyte[sac_pkg::CTRL_FLAG_BIT];
                    r_next.stm  = wbyte[sac_pkg::CTRL_STM_LSB +: 2];
                end
                default:
                begin
                end
            endcase
        end

        case (r_reg.st)
            sac_pkg::SAC_IDLE:
            begin
                if (go)
                begin
                    if (go_tm)
                    begin
                        r_next.st   = sac_pkg::SAC_TRACK;
                        r_next.tcnt = 2'h0;
                    end
                    else
                    begin
                        r_next.st   = sac_pkg::SAC_CONV;
                        r_next.bitn = sac_pkg::SAR_MSB;
                        r_next.sar  = sac_pkg::SAR_FIRST;
                    end
                end
            end
            sac_pkg::SAC_TRACK:
            begin
                if (tick)
                begin
                    if (r_reg.tcnt == sac_pkg::TRACK_LAST)
                    begin
                        r_next.st   = sac_pkg::SAC_CONV;
                        r_next.bitn = sac_pkg::SAR_MSB;
                        r_next.sar  = sac_pkg::SAR_FIRST;
                    end
                    else
                        r_next.tcnt = r_reg.tcnt + 2'h1;
                end
            end
            sac_pkg::SAC_CONV:
            begin
                if (conv_last)
                begin
                    r_next.st     = sac_pkg::SAC_IDLE;
                    r_next.sar    = sar_kept;
                    r_next.result = sar_kept;
                    r_next.flag   = 1'b1;
                end
                else if (tick)
                begin
                    r_next.sar  = sar_kept | (bit_mask >> 1);
                    r_next.bitn = r_reg.bitn - 3'h1;
                end
            end
            default:
                r_next.st = sac_pkg::SAC_IDLE;
        endcase

        // disabling drops any conversion in flight without a result, except one finishing in that cycle
        if (!r_next.en)
            r_next.st = sac_pkg::SAC_IDLE;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r_reg         <= '0;
            r_reg.st      <= sac_pkg::SAC_IDLE;
            r_reg.div     <= sac_pkg::CFG_RST[7:5];
            r_reg.gain    <= sac_pkg::CFG_RST[2:0];
            r_reg.result  <= sac_pkg::RESULT_RST;
            r_reg.gain_oh <= sac_pkg::GAIN_OH_RST;
        end
        else if (ce_i)
            r_reg <= r_next;
    end

    assign wb_dat_o     = r_reg.rdat;
    assign wb_ack_o     = r_reg.ack;
    assign conv_power_o = r_reg.en;
    // continuous track mode (tm clear) holds between conversions; sleep always wins
    assign track_o      = r_reg.en & ~sleep_i & (((~r_reg.tm) & ~busy)
                        | (r_reg.st == sac_pkg::SAC_TRACK));
    assign sel_en_o     = r_reg.sel_en;
    assign ain_sel_o    = r_reg.ain_oh;
    assign gain_sel_o   = r_reg.en ? r_reg.gain_oh : 6'h00;
    assign dac_o        = r_reg.sar;
    assign busy_o       = busy;
    assign done_flag_o  = r_reg.flag;
    assign irq_o        = r_reg.flag & int_en_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_disable_idle;
        !r_reg.en |-> !busy_o && !track_o && gain_sel_o == 6'h00;
    endproperty
    a_disable_idle: assert property (p_disable_idle)
        else $error("converter active while disabled");

    property p_gain_reset;
        $past(rst_i) |-> r_reg.gain_oh == 6'h02;
    endproperty
    a_gain_reset: assert property (p_gain_reset)
        else $error("gain not one after reset");

    property p_sw_start;
        (sw_go && !busy && ce_i) |=> busy_o;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start did not set busy");

    property p_t2_start;
        (t2_go && !busy && r_next.en && ce_i) |=> busy_o;
    endproperty
    a_t2_start: assert property (p_t2_start)
        else $error("timer overflow did not start a conversion");

    property p_done;
        (conv_last && r_reg.en && ce_i) |=> !busy_o && done_flag_o
                                           && r_reg.result == $past(sar_kept);
    endproperty
    a_done: assert property (p_done)
        else $error("finish did not set flag and result");

    property p_flag_hold;
        (done_flag_o && !(wr && idx == sac_pkg::IDX_CTRL)) |=> done_flag_o;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("complete flag dropped without a clear");

    property p_track_cont;
        (r_reg.en && !r_reg.tm && !busy && !sleep_i) |-> track_o;
    endproperty
    a_track_cont: assert property (p_track_cont)
        else $error("continuous tracking missing while idle");

    property p_track_len;
        (r_reg.st == sac_pkg::SAC_TRACK && tick && r_reg.tcnt == 2'h2 && r_reg.en && ce_i)
            |=> r_reg.st == sac_pkg::SAC_CONV;
    endproperty
    a_track_len: assert property (p_track_len)
        else $error("track phase not ended after three clocks");

    property p_sleep_track;
        sleep_i |-> !track_o;
    endproperty
    a_sleep_track: assert property (p_sleep_track)
        else $error("tracking while asleep");

    property p_no_restart;
        (busy && r_reg.st == sac_pkg::SAC_CONV && !tick && r_reg.en && ce_i)
            |=> r_reg.st == sac_pkg::SAC_CONV && $stable(r_reg.bitn);
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("conversion disturbed by a start request");

    property p_t2_sw_write;
        (wr && idx == sac_pkg::IDX_CTRL && wbyte[4] && wbyte[3:2] == 2'b11 && !busy
         && !t2_go && ce_i) |=> !busy_o;
    endproperty
    a_t2_sw_write: assert property (p_t2_sw_write)
        else $error("busy write started a conversion in timer mode");

    property p_ain_onehot;
        $onehot0(ain_sel_o) && (!sel_en_o || $onehot(ain_sel_o));
    endproperty
    a_ain_onehot: assert property (p_ain_onehot)
        else $error("input selector not one-hot");

    c_sw_conv:    cover property (sw_go ##[1:300] conv_last);
    c_t2_conv:    cover property (t2_go ##[1:300] conv_last);
    c_track:      cover property (r_reg.st == sac_pkg::SAC_TRACK ##1 r_reg.st == sac_pkg::SAC_CONV);
    c_wb_read:    cover property (acc && !wb_we_i && idx == sac_pkg::IDX_RESULT);

endmodule : sac_ctrl

// ===== shared/sac_pkg.sv
/*
 * sac_pkg: register indices, field positions, reset values, start modes,
 * conversion states and the two decoders of the converter control block.
 * Assumes a 32-bit classic Wishbone bus with one register per aligned word.
 */
package sac_pkg;

    // register word indices; byte address is four times the index
    localparam logic [7:0] IDX_INSEL     = 8'hBB;
    localparam logic [7:0] IDX_CFG       = 8'hBC;
    localparam logic [7:0] IDX_CTRL      = 8'hE8;
    localparam logic [7:0] IDX_RESULT    = 8'hBF;

    localparam logic [7:0] INSEL_RST     = 8'h00;
    localparam logic [7:0] CFG_RST       = 8'h60;
    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [7:0] RESULT_RST    = 8'h00;

    // input_select_register fields
    localparam int         INSEL_EN_BIT  = 5;
    localparam int         PORT_LSB      = 3;
    localparam int         PIN_LSB       = 0;
    // converter_config_register fields
    localparam int         CFG_DIV_LSB   = 5;
    localparam int         CFG_GAIN_LSB  = 0;
    // converter_control_register fields
    localparam int         CTRL_EN_BIT   = 7;
    localparam int         CTRL_TM_BIT   = 6;
    localparam int         CTRL_FLAG_BIT = 5;
    localparam int         CTRL_BUSY_BIT = 4;
    localparam int         CTRL_STM_LSB  = 2;

    localparam logic [1:0] STM_SW        = 2'b00;
    localparam logic [1:0] STM_T2        = 2'b11;

    localparam int         TRACK_CLKS    = 3;
    localparam logic [1:0] TRACK_LAST    = 2'(TRACK_CLKS - 1);
    localparam logic [2:0] SAR_MSB       = 3'h7;
    localparam logic [7:0] SAR_FIRST     = 8'h80;
    localparam logic [7:0] SAR_ONE       = 8'h01;

    // gain one-hot: [0]=x0.5 [1]=x1 [2]=x2 [3]=x4 [4]=x8 [5]=x16
    localparam logic [5:0] GAIN_OH_RST   = 6'h02;

    // divider terminal counts: ratio minus one
    localparam logic [3:0] DIV_LIM_1     = 4'h0;
    localparam logic [3:0] DIV_LIM_2     = 4'h1;
    localparam logic [3:0] DIV_LIM_4     = 4'h3;
    localparam logic [3:0] DIV_LIM_8     = 4'h7;
    localparam logic [3:0] DIV_LIM_16    = 4'hF;

    typedef enum logic [1:0]
    {
        SAC_IDLE  = 2'b00,
        SAC_TRACK = 2'b01,
        SAC_CONV  = 2'b10
    } sac_state_t;

    function automatic logic [3:0] sac_div_limit(input logic [2:0] code);
        logic [3:0] lim;
        lim = DIV_LIM_16;
        case (code)
            3'h0:    lim = DIV_LIM_1;
            3'h1:    lim = DIV_LIM_2;
            3'h2:    lim = DIV_LIM_4;
            3'h3:    lim = DIV_LIM_8;
            default: lim = DIV_LIM_16;
        endcase
        return lim;
    endfunction : sac_div_limit

    function automatic logic [5:0] sac_gain_onehot(input logic [2:0] code);
        logic [5:0] oh;
        oh = GAIN_OH_RST;
        case (code)
            3'h0:       oh = 6'h02;
            3'h1:       oh = 6'h04;
            3'h2:       oh = 6'h08;
            3'h3:       oh = 6'h10;
            3'h4, 3'h5: oh = 6'h20;
            default:    oh = 6'h01;
        endcase
        return oh;
    endfunction : sac_gain_onehot

endpackage : sac_pkg

// ===== shared/sac_div_if.sv
/*
 * sac_div_if: ties the conversion control to its clock divider.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
interface sac_div_if;
    logic [2:0] code;
    logic       run;
    logic       tick;

    modport ctrl
    (
        output code,
        output run,
        input  tick
    );

    modport div
    (
        input  code,
        input  run,
        output tick
    );
endinterface : sac_div_if

// ===== src/sac_clkdiv.sv
/*
 * sac_clkdiv: forms the conversion clock as a one-cycle tick every
 * 1, 2, 4, 8 or 16 system clocks while run is high.
 * Assumes code and run come from registers in the same clock domain.
 */
`timescale 1ns/100ps
module sac_clkdiv
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    sac_div_if.div    dif
);
    typedef struct packed {
        logic [3:0] cnt;
    } sac_div_regs_t;

    sac_div_regs_t r_reg;
    sac_div_regs_t r_next;
    logic [3:0]    lim;

    assign lim      = sac_pkg::sac_div_limit(dif.code);
    // counter restarts from zero with run, so the first tick of a phase
    // always comes a full conversion clock after the start
    assign dif.tick = dif.run & (r_reg.cnt == lim);

    always_comb
    begin
        r_next = r_reg;
        if (!dif.run || (r_reg.cnt >= lim))
            r_next.cnt = 4'h0;
        else
            r_next.cnt = r_reg.cnt + 4'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            r_reg <= '0;
        else if (ce_i)
            r_reg <= r_next;
    end

    property p_div_tick_len;
        @(posedge clk_i) disable iff (rst_i)
        (dif.tick && dif.code != 3'h0) |=> !dif.tick;
    endproperty
    a_div_tick_len: assert property (p_div_tick_len)
        else $error("divided tick lasted more than one cycle");

endmodule : sac_clkdiv

// ===== test/sac_far_model.sv
/*
 * sac_far_model: comparator behind the input selector, and timer 2.
 * Assumes the bench sets the analog level and shares the system clock.
 */
`timescale 1ns/100ps
module sac_far_model
#(
    parameter int PERIOD = 4
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  lvl_i,
    input  wire logic [7:0]  dac_i,
    input  wire logic [31:0] sel_i,
    input  wire logic        run_i,
    output logic             cmp_o,
    output logic             ovf_o
);
    logic [7:0] cnt_reg;
    logic       tog_reg;

    // no pin routed: the comparator sees noise, never a steady level
    assign cmp_o = (sel_i != 32'h0) ? (lvl_i >= dac_i) : tog_reg;

    always_ff @(posedge clk_i)
    begin
        tog_reg <= rst_i ? 1'b0 : ~tog_reg;
        if (rst_i || !run_i)
        begin
            cnt_reg <= 8'h00;
            ovf_o   <= 1'b0;
        end
        else
        begin
            cnt_reg <= (cnt_reg == 8'(PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
            ovf_o   <= (cnt_reg == 8'(PERIOD - 1));
        end
    end
endmodule : sac_far_model

// ===== test/tb_top.sv
/*
 * tb_top: random and corner stimulus for the converter control block.
 * Assumes classic Wishbone timing; ce_i is tied high.
 */
`timescale 1ns/100ps
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ie = 1'b0, slp = 1'b0, run = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [31:0] dat = 32'h0, q, ain, rdat;
    logic [7:0]  lvl = 8'h00, dac;
    logic [5:0]  gain;
    logic        ack, cmp, ovf, pwr, trk, sen, busy, flag, irq, b;
    int          seed = 22055, err_total = 0, total_checks = 0, cyc_cnt = 0, n, k, ps, pn;
    logic [7:0]  ix[5] = '{sac_pkg::IDX_INSEL, sac_pkg::IDX_CFG, sac_pkg::IDX_CTRL,
                           sac_pkg::IDX_RESULT, 8'h10};
    logic [7:0]  rv[5] = '{8'h00, 8'h60, 8'h00, 8'h00, 8'h00};
    logic [2:0]  dc[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

    always #2.5 clk_i = ~clk_i;

    sac_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q),
        .wb_ack_o(ack), .t2_ovf_i(ovf), .cmp_i(cmp), .sleep_i(slp), .int_en_i(ie),
        .conv_power_o(pwr), .track_o(trk), .sel_en_o(sen), .ain_sel_o(ain),
        .gain_sel_o(gain), .dac_o(dac), .busy_o(busy), .done_flag_o(flag), .irq_o(irq));

    sac_far_model #(.PERIOD(4)) FAR (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(lvl), .dac_i(dac),
        .sel_i(ain), .run_i(run), .cmp_o(cmp), .ovf_o(ovf));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("mismatches=%0d comparisons=%0d", err_total, total_checks);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // run needs about 700 cycles; the ceiling leaves ample margin
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 30000)
        begin
            err_total++;
            end_sim();
        end
    end

    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        rdat = q;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    function automatic logic [5:0] gexp(input logic [2:0] c);
        case (c)
            3'h0:       return 6'h02;
            3'h1:       return 6'h04;
            3'h2:       return 6'h08;
            3'h3:       return 6'h10;
            3'h4, 3'h5: return 6'h20;
            default:    return 6'h01;
        endcase
    endfunction : gexp

    // waits for busy, counts its cycles, then checks result and flags
    task automatic conv(input logic tm, input int nr);
        int w;
        w = 0;
        n = 0;
        while (busy !== 1'b1 && w < 200)
        begin
            @(posedge clk_i);
            w++;
        end
        chk(trk, tm);
        while (busy === 1'b1 && n < 600)
        begin
            n++;
            if (n == 5)
                run <= 1'b0;
            @(posedge clk_i);
        end
        chk(n, (tm ? 11 : 8) * nr);
        chk(flag, 1'b1);
        chk(irq, ie);
        wb(1'b0, sac_pkg::IDX_RESULT, 8'h00);
        chk(rdat, {24'h0, lvl});
        wb(1'b0, sac_pkg::IDX_CTRL, 8'h00);
        chk(rdat[5:4], 2'b10);
    endtask : conv

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 5; k++)
        begin
            wb(1'b0, ix[k], 8'h00);
            chk(rdat, {24'h0, rv[k]});
        end
        chk(pwr, 1'b0);
        chk(gain, 6'h00);
        wb(1'b1, sac_pkg::IDX_RESULT, 8'h55);
        wb(1'b0, sac_pkg::IDX_RESULT, 8'h00);
        chk(rdat, 32'h0);
        wb(1'b1, sac_pkg::IDX_CTRL, 8'h80);
        @(posedge clk_i);
        chk(pwr, 1'b1);
        chk(gain, 6'h02);
        chk(trk, 1'b1);
        slp <= 1'b1;
        @(posedge clk_i);
        @(posedge clk_i);
        chk(trk, 1'b0);
        slp <= 1'b0;
        for (k = 0; k < 5; k++)
        begin
            ps = $random(seed) & 3;
            pn = $random(seed) & 7;
            wb(1'b1, sac_pkg::IDX_INSEL, {2'b00, k != 4, ps[1:0], pn[2:0]});
            @(posedge clk_i);
            chk(ain, (k != 4) ? (32'h1 << (ps * 8 + pn)) : 32'h0);
            chk(sen, k != 4);
        end
        wb(1'b1, sac_pkg::IDX_INSEL, 8'h3F);
        for (k = 0; k < 8; k++)
        begin
            wb(1'b1, sac_pkg::IDX_CFG, {5'h00, k[2:0]});
            @(posedge clk_i);
            chk(gain, gexp(k[2:0]));
        end
        for (k = 0; k < 6; k++)
        begin
            wb(1'b1, sac_pkg::IDX_CFG, {dc[k], 5'h00});
            lvl <= 8'($random(seed));
            ie  <= 1'($random(seed));
            wb(1'b1, sac_pkg::IDX_CTRL, 8'h90);
            conv(1'b0, dc[k][2] ? 16 : (1 << dc[k][1:0]));
            wb(1'b1, sac_pkg::IDX_CTRL, 8'h80);
            @(posedge clk_i);
            chk(flag, 1'b0);
        end
        lvl <= 8'hFF;
        wb(1'b1, sac_pkg::IDX_CFG, 8'h00);
        wb(1'b1, sac_pkg::IDX_CTRL, 8'hD0);
        conv(1'b1, 1);
        b = 1'b0;
        for (k = 1; k < 4; k++)
        begin
            wb(1'b1, sac_pkg::IDX_CTRL, 8'h90 | 8'(k << 2));
            run <= (k != 3);
            repeat (12)
            begin
                @(posedge clk_i);
                b = b | busy;
            end
            run <= 1'b0;
        end
        chk(b, 1'b0);
        lvl <= 8'($random(seed));
        wb(1'b1, sac_pkg::IDX_CFG, 8'h20);
        wb(1'b1, sac_pkg::IDX_CTRL, 8'hCC);
        run <= 1'b1;
        conv(1'b1, 2);
        wb(1'b1, sac_pkg::IDX_CTRL, 8'hCC);
        @(posedge clk_i);
        chk(flag, 1'b0);
        end_sim();
    end
endmodule : tb_top
